/* hw/cpu_order_end.sv */
// Processor end: applies probes and data commands to cache status in order
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defines.svh"
// Functional notes
// - Apply probe state changes in presented order
// - System waits reply before fill after probe
// - System waits reply before release after probe
// - Second beat by probe last cycle
// - Grant-ok has virtual beats, same deadline
// - Same-class data commands apply in order
// - No miss request hitting valid victim entry
// - Release precedes probe first cycle
// - Replies return in probe order
// - One victim entry reserved for probes
// - Probe may stall on index match
module cpu_order_end #(
  parameter int VAQ_DEPTH = `PFO_VAQ_DEPTH,
  parameter int PRQ_DEPTH = `PFO_PRQ_DEPTH
) (
  input wire logic clk, // 250 MHz
  input wire logic rstn, // Async reset, low
  pfo_if.cpu lnk, // Link to system
  input wire logic miss_req, // Core asks for a block
  input wire logic [`PFO_ADDR_W-1:0] miss_addr, // Requested address
  input wire logic victim_req, // Core evicts a block
  input wire logic [`PFO_ADDR_W-1:0] victim_req_addr, // Evicted address
  output logic miss_ack, // Miss request accepted
  output logic victim_ack, // Victim accepted
  output logic fill_done, // Fill applied
  output logic [`PFO_ADDR_W-1:0] fill_addr, // Address of applied fill
  output logic release_done, // Victim entry freed
  output logic probe_done, // Probe applied
  output logic [`PFO_ADDR_W-1:0] probe_done_addr // Address of applied probe
);
  localparam int AW = `PFO_ADDR_W;
  localparam int VI = $clog2(VAQ_DEPTH);
  localparam int PI = $clog2(PRQ_DEPTH);

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_UPD = 3'b010,
    PH_REPLY = 3'b100
  } ph_t;

  typedef struct packed {
    logic [VAQ_DEPTH-1:0] vv;
    logic [VAQ_DEPTH-1:0][AW-1:0] va;
    logic [PRQ_DEPTH-1:0][AW-1:0] pa;
    logic [PRQ_DEPTH-1:0] pvh;
    logic [PI-1:0] pwr;
    logic [PI-1:0] prd;
    logic [PI:0] pcnt;
    ph_t ph;
    logic [1:0] ucnt;
    logic [AW-1:0] cur;
    logic cur_vh;
    logic cur_mh;
    logic dc_pend;
    logic [AW-1:0] dc_a;
    logic [AW-1:0] miss_a;
    logic miss_v;
    logic rep_v;
    logic rep_vh;
    logic rep_mh;
    logic [AW-1:0] rep_a;
    logic mq_v;
    logic [AW-1:0] mq_a;
    logic vo_v;
    logic [AW-1:0] vo_a;
    logic [1:0] vo_i;
    logic m_ack;
    logic v_ack;
    logic f_done;
    logic [AW-1:0] f_addr;
    logic r_done;
    logic p_done;
    logic [AW-1:0] p_addr;
    logic stall;
  } st_t;

  st_t s_r, s_nxt;

  // ***************************************************
  // Victim match and free-slot search
  // ***************************************************
  logic [VAQ_DEPTH-1:0] miss_hit, dc_hit, probe_hit, idx_hit;
  genvar g;
  for (g = 0; g < VAQ_DEPTH; g++) begin : g_vaq
    assign miss_hit[g] = s_r.vv[g] && s_r.va[g] == miss_addr;
    assign dc_hit[g] = s_r.vv[g] && s_r.va[g] == lnk.dc_addr;
    assign probe_hit[g] = s_r.vv[g] && s_r.va[g] == s_r.cur;
    assign idx_hit[g] = s_r.vv[g] &&
      s_r.va[g][`PFO_IDX_HI:`PFO_IDX_LO] == s_r.pa[s_r.prd][`PFO_IDX_HI:`PFO_IDX_LO];
  end

  logic [VI:0] used;
  logic [VI-1:0] free_i;
  logic free_ok;
  always_comb begin
    used = '0;
    free_i = '0;
    free_ok = 1'b0;
    for (int i = VAQ_DEPTH - 1; i >= 0; i--) begin
      if (s_r.vv[i]) begin
        used = used + 1'b1;
      end else begin
        free_i = VI'(i);
        free_ok = 1'b1;
      end
    end
  end

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.m_ack = 1'b0;
    s_nxt.v_ack = 1'b0;
    s_nxt.f_done = 1'b0;
    s_nxt.r_done = 1'b0;
    s_nxt.p_done = 1'b0;
    s_nxt.rep_v = 1'b0;
    s_nxt.mq_v = 1'b0;
    s_nxt.vo_v = 1'b0;

    // Probe capture on its last cycle; queue order is apply order
    if (lnk.probe_valid && lnk.probe_beat == 2'(`PFO_PROBE_CYCLES - 3'h1)) begin
      s_nxt.pa[s_r.pwr] = lnk.probe_addr;
      s_nxt.pwr = s_r.pwr + 1'b1;
      s_nxt.pcnt = s_nxt.pcnt + 1'b1;
    end

    // Grant-ok carries virtual beats so one beat flag covers both
    if (s_r.dc_pend && lnk.dc_beat_valid) begin
      s_nxt.dc_pend = 1'b0;
      s_nxt.f_done = 1'b1;
      s_nxt.f_addr = s_r.dc_a;
      if (s_r.miss_v && s_r.miss_a == s_r.dc_a) begin
        s_nxt.miss_v = 1'b0;
      end
    end
    // Data commands apply in arrival order; a new command beats a closing beat
    if (lnk.system_data_command == pfo_pkg::DC_FILL || lnk.system_data_command == pfo_pkg::DC_GRANT_OK) begin
      s_nxt.dc_pend = 1'b1;
      s_nxt.dc_a = lnk.dc_addr;
    end
    // Release frees its entry at once, before any later probe looks
    if (lnk.system_data_command == pfo_pkg::DC_RELEASE && |dc_hit) begin
      s_nxt.vv = s_r.vv & ~dc_hit;
      s_nxt.r_done = 1'b1;
    end

    // Probe pipeline: update status, then reply
    unique case (s_r.ph)
      PH_IDLE: begin
        s_nxt.stall = 1'b0;
        if (s_r.pcnt != '0) begin
          // One extra cycle per matching probe, then it proceeds
          if (|idx_hit && !s_r.pvh[s_r.prd]) begin
            s_nxt.stall = 1'b1;
            s_nxt.pvh[s_r.prd] = 1'b1;
          end else begin
            s_nxt.cur = s_r.pa[s_r.prd];
            s_nxt.ph = PH_UPD;
            s_nxt.ucnt = '0;
          end
        end
      end
      PH_UPD: begin
        s_nxt.ucnt = s_r.ucnt + 1'b1;
        s_nxt.cur_vh = |probe_hit;
        s_nxt.cur_mh = s_r.miss_v && s_r.miss_a == s_r.cur;
        if (s_r.ucnt == `PFO_UPD_CYCLES - 2'h1) begin
          s_nxt.p_done = 1'b1;
          s_nxt.p_addr = s_r.cur;
          s_nxt.ph = PH_REPLY;
        end
      end
      PH_REPLY: begin
        s_nxt.rep_v = 1'b1;
        s_nxt.rep_vh = s_r.cur_vh;
        s_nxt.rep_mh = s_r.cur_mh;
        s_nxt.rep_a = s_r.cur;
        s_nxt.pvh[s_r.prd] = 1'b0;
        s_nxt.prd = s_r.prd + 1'b1;
        s_nxt.pcnt = s_nxt.pcnt - 1'b1;
        s_nxt.ph = PH_IDLE;
      end
    endcase

    // Miss requests never target a held victim
    if (miss_req && !s_r.miss_v && !(|miss_hit)) begin
      s_nxt.miss_v = 1'b1;
      s_nxt.miss_a = miss_addr;
      s_nxt.mq_v = 1'b1;
      s_nxt.mq_a = miss_addr;
      s_nxt.m_ack = 1'b1;
    end
    // Last free entry kept back so probes never wait on a full queue
    if (victim_req && free_ok && used < (VI+1)'(VAQ_DEPTH - 1)) begin
      s_nxt.vv[free_i] = 1'b1;
      s_nxt.va[free_i] = victim_req_addr;
      s_nxt.vo_v = 1'b1;
      s_nxt.vo_a = victim_req_addr;
      s_nxt.vo_i = 2'(free_i);
      s_nxt.v_ack = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.ph <= PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign lnk.probe_stall = s_r.stall;
  assign lnk.snoop_reply_valid = s_r.rep_v;
  assign lnk.snoop_reply_vaq_hit = s_r.rep_vh;
  assign lnk.snoop_reply_miss_hit = s_r.rep_mh;
  assign lnk.snoop_reply_addr = s_r.rep_a;
  assign lnk.miss_req_valid = s_r.mq_v;
  assign lnk.miss_req_addr = s_r.mq_a;
  assign lnk.victim_valid = s_r.vo_v;
  assign lnk.victim_addr = s_r.vo_a;
  assign lnk.victim_idx = s_r.vo_i;
  assign miss_ack = s_r.m_ack;
  assign victim_ack = s_r.v_ack;
  assign fill_done = s_r.f_done;
  assign fill_addr = s_r.f_addr;
  assign release_done = s_r.r_done;
  assign probe_done = s_r.p_done;
  assign probe_done_addr = s_r.p_addr;
endmodule : cpu_order_end
`default_nettype wire

/* hw/pfo_defines.svh */
// Constants for the probe and fill ordering link
`ifndef PFO_DEFINES_SVH
`define PFO_DEFINES_SVH
`define PFO_ADDR_W 34
`define PFO_IDX_LO 6
`define PFO_IDX_HI 19
`define PFO_PROBE_CYCLES 3'h4
`define PFO_VAQ_DEPTH 4
`define PFO_PRQ_DEPTH 4
`define PFO_UPD_CYCLES 2'h2
`endif

/* hw/pfo_if.sv */
// Link between the processor end and the system controller end
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defines.svh"
interface pfo_if;
  logic probe_valid;
  logic [1:0] probe_beat;
  logic [`PFO_ADDR_W-1:0] probe_addr;
  pfo_pkg::probe_next_t probe_next;
  logic probe_stall;
  pfo_pkg::dc_cmd_t system_data_command;
  logic [`PFO_ADDR_W-1:0] dc_addr;
  logic dc_beat_valid;
  logic [63:0] dc_data;
  logic snoop_reply_valid;
  logic snoop_reply_vaq_hit;
  logic snoop_reply_miss_hit;
  logic [`PFO_ADDR_W-1:0] snoop_reply_addr;
  logic miss_req_valid;
  logic [`PFO_ADDR_W-1:0] miss_req_addr;
  logic victim_valid;
  logic [`PFO_ADDR_W-1:0] victim_addr;
  logic [1:0] victim_idx;
  modport cpu (
    input probe_valid, probe_beat, probe_addr, probe_next, system_data_command, dc_addr, dc_beat_valid, dc_data,
    output probe_stall, snoop_reply_valid, snoop_reply_vaq_hit, snoop_reply_miss_hit, snoop_reply_addr,
    output miss_req_valid, miss_req_addr, victim_valid, victim_addr, victim_idx
  );
  modport sys (
    output probe_valid, probe_beat, probe_addr, probe_next, system_data_command, dc_addr, dc_beat_valid, dc_data,
    input probe_stall, snoop_reply_valid, snoop_reply_vaq_hit, snoop_reply_miss_hit, snoop_reply_addr,
    input miss_req_valid, miss_req_addr, victim_valid, victim_addr, victim_idx
  );
endinterface : pfo_if
`default_nettype wire

/* hw/pfo_pkg.sv */
// Types shared by both ends of the probe and fill ordering link
package pfo_pkg;
  typedef enum logic [2:0] {
    DC_NONE = 3'h0,
    DC_FILL = 3'h1,
    DC_GRANT_OK = 3'h2,
    DC_RELEASE = 3'h3
  } dc_cmd_t;
  typedef enum logic [1:0] {
    PS_INVAL = 2'h0,
    PS_SHARED = 2'h1,
    PS_KEEP = 2'h2
  } probe_next_t;
endpackage : pfo_pkg

/* hw/sys_order_end.sv */
// System end: sequences probes and data commands with ordering waits
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defines.svh"
module sys_order_end (
  input wire logic clk, // 250 MHz
  input wire logic rstn, // Async reset, low
  pfo_if.sys lnk, // Link to processor
  input wire logic probe_req, // Send a probe
  input wire logic [`PFO_ADDR_W-1:0] probe_req_addr, // Probe address
  input wire pfo_pkg::probe_next_t probe_req_next, // Next state
  input wire logic dc_req, // Send a data command
  input wire pfo_pkg::dc_cmd_t dc_req_cmd, // Which command
  input wire logic [`PFO_ADDR_W-1:0] dc_req_addr, // Command address
  input wire logic [63:0] dc_req_data, // Fill data
  output logic probe_ack, // Probe taken
  output logic dc_ack, // Data command taken
  output logic reply_seen, // Reply received
  output logic reply_vaq_hit // Reply victim hit
);
  typedef enum logic [3:0] {
    SS_IDLE = 4'b0001,
    SS_PROBE = 4'b0010,
    SS_BEAT = 4'b0100,
    SS_WAIT = 4'b1000
  } ss_t;

  typedef struct packed {
    ss_t st;
    logic [2:0] cnt;
    logic outstanding;
    logic pv;
    logic [1:0] pb;
    logic [`PFO_ADDR_W-1:0] pa;
    pfo_pkg::probe_next_t pn;
    pfo_pkg::dc_cmd_t dc;
    logic [`PFO_ADDR_W-1:0] da;
    logic bv;
    logic [63:0] dd;
    logic p_ack;
    logic d_ack;
    logic r_seen;
    logic r_vh;
  } st_t;

  st_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.dc = pfo_pkg::DC_NONE;
    s_nxt.bv = 1'b0;
    s_nxt.p_ack = 1'b0;
    s_nxt.d_ack = 1'b0;
    s_nxt.r_seen = lnk.snoop_reply_valid;
    s_nxt.r_vh = lnk.snoop_reply_vaq_hit;
    if (lnk.snoop_reply_valid) begin
      s_nxt.outstanding = 1'b0;
    end
    unique case (s_r.st)
      SS_IDLE: begin
        s_nxt.pv = 1'b0;
        // Data commands wait for any probe reply still owed
        if (dc_req && !s_r.outstanding && !lnk.snoop_reply_valid) begin
          s_nxt.dc = dc_req_cmd;
          s_nxt.da = dc_req_addr;
          s_nxt.dd = dc_req_data;
          s_nxt.d_ack = 1'b1;
          // Release needs no beat; it lands ahead of the next probe
          s_nxt.st = (dc_req_cmd == pfo_pkg::DC_RELEASE) ? SS_IDLE : SS_BEAT;
        end else if (probe_req && !s_r.outstanding) begin
          s_nxt.pv = 1'b1;
          s_nxt.pb = '0;
          s_nxt.pa = probe_req_addr;
          s_nxt.pn = probe_req_next;
          s_nxt.p_ack = 1'b1;
          s_nxt.outstanding = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st = SS_PROBE;
        end
      end
      SS_BEAT: begin
        // Second beat before any probe starts, also virtual for grant-ok
        s_nxt.bv = 1'b1;
        s_nxt.st = SS_IDLE;
      end
      SS_PROBE: begin
        s_nxt.cnt = s_r.cnt + 3'h1;
        s_nxt.pb = s_r.pb + 2'h1;
        if (s_r.cnt == `PFO_PROBE_CYCLES - 3'h1) begin
          s_nxt.pv = 1'b0;
          s_nxt.st = SS_IDLE;
        end
      end
      SS_WAIT: begin
        s_nxt.st = SS_IDLE;
      end
      default: begin
        s_nxt.st = SS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= SS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.probe_valid = s_r.pv;
  assign lnk.probe_beat = s_r.pb;
  assign lnk.probe_addr = s_r.pa;
  assign lnk.probe_next = s_r.pn;
  assign lnk.system_data_command = s_r.dc;
  assign lnk.dc_addr = s_r.da;
  assign lnk.dc_beat_valid = s_r.bv;
  assign lnk.dc_data = s_r.dd;
  assign probe_ack = s_r.p_ack;
  assign dc_ack = s_r.d_ack;
  assign reply_seen = s_r.r_seen;
  assign reply_vaq_hit = s_r.r_vh;
endmodule : sys_order_end
`default_nettype wire

/* sim/pfo_sva.sv */
// Ordering checks on the probe and data command link
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defines.svh"
module pfo_sva (
  input wire logic clk, // Link clock
  input wire logic rstn, // Async reset, low
  input wire logic probe_valid, // Probe beat valid
  input wire logic [1:0] probe_beat, // Probe beat number
  input wire pfo_pkg::dc_cmd_t system_data_command, // Data command
  input wire logic dc_beat_valid, // Second quadword beat
  input wire logic snoop_reply_valid, // Reply pulse
  input wire logic victim_valid // Victim entry allocated
);
  // ****************************************
  // Helper state
  // ****************************************
  logic owed_r;
  logic [2:0] vcnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owed_r <= 1'b0;
      vcnt_r <= 3'h0;
    end else begin
      if (probe_valid && probe_beat == 2'h3) owed_r <= 1'b1;
      else if (snoop_reply_valid) owed_r <= 1'b0;
      vcnt_r <= vcnt_r + 3'(victim_valid) - 3'(system_data_command == pfo_pkg::DC_RELEASE);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence beats_s;
    probe_valid && probe_beat == 2'h1 ##1 probe_valid && probe_beat == 2'h2 ##1 probe_valid && probe_beat == 2'h3;
  endsequence
  sequence last_beat_s;
    probe_valid && probe_beat == 2'h3;
  endsequence
  a_probe_four_beats:
    assert property (probe_valid && probe_beat == 2'h0 |=> beats_s) else $error("probe frame not four beats");
  a_beat_follows_cmd:
    assert property (system_data_command inside {pfo_pkg::DC_FILL, pfo_pkg::DC_GRANT_OK} |=> dc_beat_valid)
    else $error("second beat missing");
  a_release_no_beat:
    assert property (system_data_command == pfo_pkg::DC_RELEASE |=> !dc_beat_valid) else $error("beat after release");
  a_dc_after_reply:
    assert property (system_data_command != pfo_pkg::DC_NONE |-> !owed_r) else $error("data command before reply");
  a_probe_after_reply:
    assert property (probe_valid && probe_beat == 2'h0 |-> !owed_r) else $error("probe before reply");
  a_reply_in_time:
    assert property (last_beat_s |-> ##[3:10] snoop_reply_valid) else $error("reply late");
  a_reply_owed:
    assert property (snoop_reply_valid |-> owed_r && !$past(snoop_reply_valid)) else $error("reply not owed");
  a_vaq_reserve:
    assert property (victim_valid |-> vcnt_r < 3'h3) else $error("reserved victim entry taken");
  a_release_out_probe:
    assert property (system_data_command == pfo_pkg::DC_RELEASE |-> !probe_valid) else $error("release inside probe");
endmodule : pfo_sva
`default_nettype wire

/* sim/probe_fill_order_control_test.sv */
// Bench joining both ends of the probe and data command link
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defines.svh"
module probe_fill_order_control_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic miss_req = 1'b0;
  logic victim_req = 1'b0;
  logic probe_req = 1'b0;
  logic dc_req = 1'b0;
  logic [`PFO_ADDR_W-1:0] miss_addr = '0, victim_req_addr = '0, probe_req_addr = '0, dc_req_addr = '0;
  pfo_pkg::probe_next_t probe_req_next = pfo_pkg::PS_INVAL;
  pfo_pkg::dc_cmd_t dc_req_cmd = pfo_pkg::DC_NONE;
  logic [63:0] dc_req_data = 64'h1234_5678_9abc_def0;
  logic miss_ack, victim_ack, fill_done, release_done, probe_done, probe_ack, dc_ack, reply_seen, reply_vaq_hit;
  logic [`PFO_ADDR_W-1:0] fill_addr, probe_done_addr;
  logic ok;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n_reply = 0, n_rel = 0, n_stall = 0;
  logic [`PFO_ADDR_W:0] ev_q[$];
  pfo_if lnk();
  always #2 clk = ~clk;
  cpu_order_end cpu_order_end_i (.clk(clk), .rstn(rstn), .lnk(lnk), .miss_req(miss_req), .miss_addr(miss_addr),
    .victim_req(victim_req), .victim_req_addr(victim_req_addr), .miss_ack(miss_ack), .victim_ack(victim_ack),
    .fill_done(fill_done), .fill_addr(fill_addr), .release_done(release_done), .probe_done(probe_done),
    .probe_done_addr(probe_done_addr));
  sys_order_end sys_order_end_i (.clk(clk), .rstn(rstn), .lnk(lnk), .probe_req(probe_req),
    .probe_req_addr(probe_req_addr), .probe_req_next(probe_req_next), .dc_req(dc_req), .dc_req_cmd(dc_req_cmd),
    .dc_req_addr(dc_req_addr), .dc_req_data(dc_req_data), .probe_ack(probe_ack), .dc_ack(dc_ack),
    .reply_seen(reply_seen), .reply_vaq_hit(reply_vaq_hit));
  pfo_sva pfo_sva_i (.clk(clk), .rstn(rstn), .probe_valid(lnk.probe_valid), .probe_beat(lnk.probe_beat),
    .system_data_command(lnk.system_data_command), .dc_beat_valid(lnk.dc_beat_valid),
    .snoop_reply_valid(lnk.snoop_reply_valid), .victim_valid(lnk.victim_valid));
  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(negedge clk) begin
    if (fill_done === 1'b1) ev_q.push_back({1'b1, fill_addr});
    if (probe_done === 1'b1) ev_q.push_back({1'b0, probe_done_addr});
    if (reply_seen === 1'b1) n_reply++;
    if (release_done === 1'b1) n_rel++;
    if (lnk.probe_stall === 1'b1) n_stall++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [`PFO_ADDR_W:0] got, input logic [`PFO_ADDR_W:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send_probe(input logic [`PFO_ADDR_W-1:0] a);
    probe_req_addr = a;
    probe_req = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 40 && probe_ack !== 1'b1; i++) @(negedge clk);
    probe_req = 1'b0;
    if (probe_ack !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: probe not taken", $time);
    end
    @(negedge clk);
  endtask : send_probe
  task automatic send_dc(input pfo_pkg::dc_cmd_t c, input logic [`PFO_ADDR_W-1:0] a);
    dc_req_cmd = c;
    dc_req_addr = a;
    dc_req = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 40 && dc_ack !== 1'b1; i++) @(negedge clk);
    dc_req = 1'b0;
    if (dc_ack !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: data command not taken", $time);
    end
    @(negedge clk);
  endtask : send_dc
  // Refused requests never ack, so the hold is capped
  task automatic core_req(input logic vic, input logic [`PFO_ADDR_W-1:0] a, output logic seen);
    miss_addr = a;
    victim_req_addr = a;
    miss_req = !vic;
    victim_req = vic;
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(negedge clk);
      seen = vic ? victim_ack === 1'b1 : miss_ack === 1'b1;
    end
    miss_req = 1'b0;
    victim_req = 1'b0;
    @(negedge clk);
  endtask : core_req
  task automatic settle;
    repeat (16) @(negedge clk);
  endtask : settle
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic probe_order;
    ev_q.delete();
    n_reply = 0;
    send_probe(34'h0_0000_1040);
    send_probe(34'h0_0000_2080);
    settle;
    chk(ev_q.size(), 2);
    chk(ev_q[0], {1'b0, 34'h0_0000_1040});
    chk(ev_q[1], {1'b0, 34'h0_0000_2080});
    chk(n_reply, 2);
    chk(lnk.snoop_reply_addr, 34'h0_0000_2080);
  endtask : probe_order
  task automatic data_then_probe;
    for (int k = 0; k < 2; k++) begin
      ev_q.delete();
      send_dc(k ? pfo_pkg::DC_GRANT_OK : pfo_pkg::DC_FILL, 34'h0_0003_0100);
      send_dc(k ? pfo_pkg::DC_GRANT_OK : pfo_pkg::DC_FILL, 34'h0_0003_0140);
      send_probe(34'h0_0003_0100);
      settle;
      chk(ev_q[0], {1'b1, 34'h0_0003_0100});
      chk(ev_q[1], {1'b1, 34'h0_0003_0140});
      chk(ev_q[2], {1'b0, 34'h0_0003_0100});
    end
  endtask : data_then_probe
  task automatic victim_cycle;
    n_rel = 0;
    n_stall = 0;
    core_req(1'b1, 34'h0_0005_0200, ok);
    chk(ok, 1'b1);
    core_req(1'b0, 34'h0_0005_0200, ok);
    chk(ok, 1'b0);
    send_probe(34'h0_0005_0200);
    send_probe(34'h0_0005_0200);
    settle;
    chk(reply_vaq_hit, 1'b1);
    chk(n_stall, 2);
    send_dc(pfo_pkg::DC_RELEASE, 34'h0_0005_0200);
    send_probe(34'h0_0005_0200);
    settle;
    chk(n_rel, 1);
    chk(reply_vaq_hit, 1'b0);
    core_req(1'b0, 34'h0_0005_0200, ok);
    chk(ok, 1'b1);
    send_dc(pfo_pkg::DC_FILL, 34'h0_0005_0200);
    settle;
  endtask : victim_cycle
  task automatic victim_full;
    n_rel = 0;
    for (int k = 0; k < 4; k++) begin
      core_req(1'b1, 34'h0_0007_0000 + 34'(k * 64), ok);
      chk(ok, k < 3);
    end
    for (int k = 0; k < 3; k++) send_dc(pfo_pkg::DC_RELEASE, 34'h0_0007_0000 + 34'(k * 64));
    settle;
    chk(n_rel, 3);
  endtask : victim_full
  task automatic complete_run;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    probe_order;
    data_then_probe;
    victim_cycle;
    victim_full;
    complete_run;
  end
endmodule : probe_fill_order_control_test
`default_nettype wire
